// File: dpll_div_pkg.sv
// Constants for the DPLL input dividers: register indices, field positions and reset values.
// Assumes a classic Wishbone slave with 32-bit data, where byte address = 4 x register index.
// Summary of operation
// - Reference count is 16 bits, ratio value plus one.
// - Lower byte bits 7..0, next byte 15..8.
// - Reference control bit 7 inverts reference clock.
// - Reference control bit 0 adds divide-by-two prescaler.
// - Feedback count is 16 bits, ratio value plus one.
// - Feedback lower byte 7..0, next byte 15..8.
// - Feedback control bit 7 inverts feedback clock.
// - Feedback control bit 0 adds divide-by-two prescaler.
// - Control bits 6..1 reserved, no effect.
package dpll_div_pkg;

  // Bus geometry.
  localparam int ADDR_W = 12;                  // Byte address width on the bus.
  localparam int IDX_W  = 10;                  // Register index width (byte address / 4).
  localparam int DAT_W  = 32;                  // Bus data width.
  localparam int CNT_W  = 16;                  // Divider count width.

  // Register indices as printed; the byte address is four times each index.
  localparam logic [IDX_W-1:0] IDX_REF_LOW   = 10'h101;
  localparam logic [IDX_W-1:0] IDX_REF_HIGH  = 10'h102;
  localparam logic [IDX_W-1:0] IDX_REF_CTRL  = 10'h103;
  localparam logic [IDX_W-1:0] IDX_FB_LOW    = 10'h104;
  localparam logic [IDX_W-1:0] IDX_FB_HIGH   = 10'h105;
  localparam logic [IDX_W-1:0] IDX_FB_CTRL   = 10'h106;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 10'h180;

  // Control byte field positions.
  localparam int CTRL_INVERT_BIT   = 7;        // Count on the opposite input edge.
  localparam int CTRL_PRESCALE_BIT = 0;        // Extra divide-by-two ahead of the counter.

  // Status field positions.
  localparam int STAT_REF_TOGGLE_BIT = 0;      // Flips on every reference output pulse.
  localparam int STAT_FB_TOGGLE_BIT  = 1;      // Flips on every feedback output pulse.

  // Reset values.
  localparam logic [7:0]       RST_COUNT_BYTE = 8'h00;
  localparam logic             RST_CTRL_BIT   = 1'b0;
  localparam logic [CNT_W-1:0] RST_LIMIT      = 16'h0000;

endpackage

// File: clock_edge_divider.sv
// One programmable divider: edge select, optional divide-by-two and a 16-bit counter.
// Assumes the divided clock arrives as a level synchronous to clk, below half the clk rate.
`timescale 1ns/1ps
module clock_edge_divider
  import dpll_div_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clockIn,
  input  wire logic             invert,
  input  wire logic             prescale,
  input  wire logic [WIDTH-1:0] countValue,
  output logic                  pulse,
  output logic                  toggle
);

  logic             sampled;       // Input after optional inversion.
  logic             prev_q;        // Input one cycle ago.
  logic             inEdge;        // Active edge seen this cycle.
  logic             half_q;        // Prescaler phase.
  logic             preEn_q;       // Prescaler setting in force for this count.
  logic             countEdge;     // Edge that advances the counter.
  logic [WIDTH-1:0] cnt_q;         // Edges counted so far in this period.
  logic [WIDTH-1:0] limit_q;       // Terminal value in force for this period.
  logic             terminal;      // Counter sits on its terminal value.
  logic             wrap;          // Period completes this cycle.
  logic             pulse_q;       // Registered output pulse.
  logic             toggle_q;      // Registered toggle, flips per pulse.

  // Selecting the edge by inversion keeps one edge detector for both modes.
  assign sampled   = clockIn ^ invert;
  assign inEdge    = sampled & ~prev_q;
  // With the prescaler on, only every second active edge reaches the counter.
  assign countEdge = preEn_q ? (inEdge & half_q) : inEdge;
  assign terminal  = (cnt_q == limit_q);
  assign wrap      = countEdge & terminal;
  assign pulse     = pulse_q;
  assign toggle    = toggle_q;

  // Edge history and prescaler phase.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q <= 1'b0;
      half_q <= 1'b0;
    end
    else
    begin
      prev_q <= sampled;
      if (inEdge)
      begin
        half_q <= ~half_q;
      end
    end
  end

  // Counter: new count and prescaler settings are taken only at a wrap, so a count change cuts no period short.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q    <= RST_LIMIT;
      limit_q  <= RST_LIMIT;
      preEn_q  <= RST_CTRL_BIT;
      pulse_q  <= 1'b0;
      toggle_q <= 1'b0;
    end
    else
    begin
      pulse_q <= wrap;
      if (wrap)
      begin
        cnt_q    <= '0;
        limit_q  <= countValue;
        preEn_q  <= prescale;
        toggle_q <= ~toggle_q;
      end
      else if (countEdge)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // A pulse follows exactly the cycle of a wrap.
  property p_pulse_on_wrap;
    @(posedge clk) disable iff (rst) wrap |=> pulse_q;
  endproperty
  a_pulse_on_wrap: assert property (p_pulse_on_wrap)
    else $error("Divider wrap did not produce an output pulse.");

  // The terminal value changes only at a wrap.
  property p_limit_at_wrap;
    @(posedge clk) disable iff (rst) !$stable(limit_q) |-> $past(wrap);
  endproperty
  a_limit_at_wrap: assert property (p_limit_at_wrap)
    else $error("Divider count changed outside a terminal count.");

  // The counter never passes its terminal value, so the ratio is value plus one.
  property p_count_bound;
    @(posedge clk) disable iff (rst) cnt_q <= limit_q;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("Divider counter passed its terminal value.");

  // With the prescaler on, two adjacent active edges never both advance the counter.
  // An advancing edge closes its pair, so the following edge can only open a new one.
  property p_prescale_skip;
    @(posedge clk) disable iff (rst) (countEdge && preEn_q) |=> !half_q;
  endproperty
  a_prescale_skip: assert property (p_prescale_skip)
    else $error("Divider prescaler let two adjacent edges advance the count.");

endmodule

// File: dpll_ref_feedback_dividers.sv
// Reference and feedback dividers of the DPLL input stage with their Wishbone register file.
// Assumes a classic Wishbone master on clk, both clock inputs synchronous to clk and slower
// than half its rate, and a phase detector downstream that takes one-cycle pulses.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module dpll_ref_feedback_dividers
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  // Classic Wishbone slave port.
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic                              we_i,
  input  wire logic [dpll_div_pkg::ADDR_W-1:0]   adr_i,
  input  wire logic [3:0]                        sel_i,
  input  wire logic [dpll_div_pkg::DAT_W-1:0]    dat_i,
  output logic      [dpll_div_pkg::DAT_W-1:0]    dat_o,
  output logic                                   ack_o,
  // Selected reference clock and the feedback clock.
  input  wire logic                              referenceClock,
  input  wire logic                              feedbackClockInput,
  // Divided outputs towards the phase detector.
  output logic                                   refDivPulse,
  output logic                                   fbDivPulse
);
  import dpll_div_pkg::*;

  // Bus request and decode.
  logic             ack_q;          // Registered acknowledge.
  logic [DAT_W-1:0] rdata_q;        // Registered read data.
  logic [DAT_W-1:0] rdata_d;        // Read data selected for the current address.
  logic             reqTaken;       // A new request is taken on this edge.
  logic             wrTaken;        // A write with the low byte lane enabled.
  logic [IDX_W-1:0] regIndex;       // Word index of the request.
  logic             hitRefLow;      // Address matches each register.
  logic             hitRefHigh;
  logic             hitRefCtrl;
  logic             hitFbLow;
  logic             hitFbHigh;
  logic             hitFbCtrl;
  logic             hitStatus;

  // Register storage; reserved control bits are not stored at all.
  logic [7:0]       refCountLow_q;  // Reference count bits 7..0.
  logic [7:0]       refCountHigh_q; // Reference count bits 15..8.
  logic             refInvert_q;    // Reference falling edge select.
  logic             refPrescale_q;  // Reference divide-by-two enable.
  logic [7:0]       fbCountLow_q;   // Feedback count bits 7..0.
  logic [7:0]       fbCountHigh_q;  // Feedback count bits 15..8.
  logic             fbInvert_q;     // Feedback falling edge select.
  logic             fbPrescale_q;   // Feedback divide-by-two enable.

  // Assembled divider settings and state.
  logic [CNT_W-1:0] refCount;       // Full reference count.
  logic [CNT_W-1:0] fbCount;        // Full feedback count.
  logic [7:0]       refCtrlByte;    // Reference control byte as read back.
  logic [7:0]       fbCtrlByte;     // Feedback control byte as read back.
  logic [7:0]       statusByte;     // Live divider state.
  logic             refToggle;      // Flips on every reference output pulse.
  logic             fbToggle;       // Flips on every feedback output pulse.

  // A request is taken once; the held request is not taken again while ack is high.
  assign reqTaken = cyc_i & stb_i & ~ack_q;
  assign wrTaken  = reqTaken & we_i & sel_i[0];
  assign regIndex = adr_i[ADDR_W-1:2];

  // Address decoding against the word index.
  assign hitRefLow  = (regIndex == IDX_REF_LOW);
  assign hitRefHigh = (regIndex == IDX_REF_HIGH);
  assign hitRefCtrl = (regIndex == IDX_REF_CTRL);
  assign hitFbLow   = (regIndex == IDX_FB_LOW);
  assign hitFbHigh  = (regIndex == IDX_FB_HIGH);
  assign hitFbCtrl  = (regIndex == IDX_FB_CTRL);
  assign hitStatus  = (regIndex == IDX_STATUS);

  // The lower address holds the low byte of each count.
  assign refCount = {refCountHigh_q, refCountLow_q};
  assign fbCount  = {fbCountHigh_q, fbCountLow_q};

  // Reserved control bits read back as zero.
  assign refCtrlByte = {refInvert_q, 6'h00, refPrescale_q};
  assign fbCtrlByte  = {fbInvert_q, 6'h00, fbPrescale_q};
  assign statusByte  = {6'h00, fbToggle, refToggle};

  // Read selection; an unmapped index returns zero and is still acknowledged.
  always_comb
  begin
    rdata_d = '0;
    if (hitRefLow)
    begin
      rdata_d[7:0] = refCountLow_q;
    end
    else if (hitRefHigh)
    begin
      rdata_d[7:0] = refCountHigh_q;
    end
    else if (hitRefCtrl)
    begin
      rdata_d[7:0] = refCtrlByte;
    end
    else if (hitFbLow)
    begin
      rdata_d[7:0] = fbCountLow_q;
    end
    else if (hitFbHigh)
    begin
      rdata_d[7:0] = fbCountHigh_q;
    end
    else if (hitFbCtrl)
    begin
      rdata_d[7:0] = fbCtrlByte;
    end
    else if (hitStatus)
    begin
      rdata_d[7:0] = statusByte;
    end
  end

  // Acknowledge and read data: one cycle after the request; ack drops the cycle after, read data holds until the next read.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= reqTaken;
      if (reqTaken && !we_i)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata_q;

  // Reference divider registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      refCountLow_q  <= RST_COUNT_BYTE;
      refCountHigh_q <= RST_COUNT_BYTE;
      refInvert_q    <= RST_CTRL_BIT;
      refPrescale_q  <= RST_CTRL_BIT;
    end
    else if (wrTaken)
    begin
      if (hitRefLow)
      begin
        refCountLow_q <= dat_i[7:0];
      end
      if (hitRefHigh)
      begin
        refCountHigh_q <= dat_i[7:0];
      end
      if (hitRefCtrl)
      begin
        // Bits 6..1 of the written byte are dropped.
        refInvert_q   <= dat_i[CTRL_INVERT_BIT];
        refPrescale_q <= dat_i[CTRL_PRESCALE_BIT];
      end
    end
  end

  // Feedback divider registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fbCountLow_q  <= RST_COUNT_BYTE;
      fbCountHigh_q <= RST_COUNT_BYTE;
      fbInvert_q    <= RST_CTRL_BIT;
      fbPrescale_q  <= RST_CTRL_BIT;
    end
    else if (wrTaken)
    begin
      if (hitFbLow)
      begin
        fbCountLow_q <= dat_i[7:0];
      end
      if (hitFbHigh)
      begin
        fbCountHigh_q <= dat_i[7:0];
      end
      if (hitFbCtrl)
      begin
        fbInvert_q   <= dat_i[CTRL_INVERT_BIT];
        fbPrescale_q <= dat_i[CTRL_PRESCALE_BIT];
      end
    end
  end

  // Reference path. Ratios above 65,536 rely on software having set the prescaler, which sits behind the
  // edge detector and so does not raise the input rate limit; nothing here checks the input rate.
  clock_edge_divider #(
    .WIDTH      (CNT_W)
  ) u_ref_div (
    .clk        (clk),
    .rst        (rst),
    .clockIn    (referenceClock),
    .invert     (refInvert_q),
    .prescale   (refPrescale_q),
    .countValue (refCount),
    .pulse      (refDivPulse),
    .toggle     (refToggle)
  );

  // Feedback path, identical structure.
  clock_edge_divider #(
    .WIDTH      (CNT_W)
  ) u_fb_div (
    .clk        (clk),
    .rst        (rst),
    .clockIn    (feedbackClockInput),
    .invert     (fbInvert_q),
    .prescale   (fbPrescale_q),
    .countValue (fbCount),
    .pulse      (fbDivPulse),
    .toggle     (fbToggle)
  );

  // Bus handshake sequences used below.
  sequence s_write_low_ref;
    wrTaken && hitRefLow;
  endsequence

  sequence s_write_high_fb;
    wrTaken && hitFbHigh;
  endsequence

  // A write to the reference low byte lands in count bits 7..0.
  property p_ref_low_write;
    @(posedge clk) disable iff (rst)
      s_write_low_ref |=> (refCount[7:0] == $past(dat_i[7:0]));
  endproperty
  a_ref_low_write: assert property (p_ref_low_write)
    else $error("Reference low byte write did not reach count bits 7..0.");

  // A write to the feedback high byte lands in count bits 15..8.
  property p_fb_high_write;
    @(posedge clk) disable iff (rst)
      s_write_high_fb |=> (fbCount[15:8] == $past(dat_i[7:0]));
  endproperty
  a_fb_high_write: assert property (p_fb_high_write)
    else $error("Feedback high byte write did not reach count bits 15..8.");

  // Reserved control bits always read as zero.
  property p_ctrl_reserved;
    @(posedge clk) disable iff (rst)
      (reqTaken && !we_i && (hitRefCtrl || hitFbCtrl)) |=> (dat_o[6:1] == 6'h00);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("Reserved control bits did not read as zero.");

  // Control writes take the invert bit from bit 7 only.
  property p_ref_invert_write;
    @(posedge clk) disable iff (rst)
      (wrTaken && hitRefCtrl) |=> (refInvert_q == $past(dat_i[7]));
  endproperty
  a_ref_invert_write: assert property (p_ref_invert_write)
    else $error("Reference invert bit not taken from bit 7.");

  // Control writes take the prescaler enable from bit 0 only.
  property p_fb_prescale_write;
    @(posedge clk) disable iff (rst)
      (wrTaken && hitFbCtrl) |=> (fbPrescale_q == $past(dat_i[0]));
  endproperty
  a_fb_prescale_write: assert property (p_fb_prescale_write)
    else $error("Feedback prescaler bit not taken from bit 0.");

  // Each request gets exactly one ack one cycle later, then ack drops.
  property p_ack_once;
    @(posedge clk) disable iff (rst) reqTaken |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("Bus acknowledge was not a single cycle after the request.");

  // Unmapped reads return zero.
  property p_unmapped_zero;
    @(posedge clk) disable iff (rst)
      (reqTaken && !we_i && !(hitRefLow || hitRefHigh || hitRefCtrl || hitFbLow ||
        hitFbHigh || hitFbCtrl || hitStatus)) |=> (dat_o == '0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Unmapped read did not return zero.");

  // With invert set, a falling input edge yields an edge detect inside the divider.
  property p_fb_invert_edge;
    @(posedge clk) disable iff (rst)
      (fbInvert_q && $past(fbInvert_q) && $fell(feedbackClockInput)) |-> u_fb_div.inEdge;
  endproperty
  a_fb_invert_edge: assert property (p_fb_invert_edge)
    else $error("Inverted feedback clock did not count on the falling edge.");

  // Outputs are pulses: never high on two cycles in a row at these rates.
  property p_ref_pulse_single;
    @(posedge clk) disable iff (rst) refDivPulse |=> !refDivPulse;
  endproperty
  a_ref_pulse_single: assert property (p_ref_pulse_single)
    else $error("Reference divider pulse lasted more than one cycle.");

  // A stored zero with no prescaler divides by one: each rising edge gives a pulse.
  property p_ref_div_one;
    @(posedge clk) disable iff (rst)
      (u_ref_div.limit_q == '0 && !u_ref_div.preEn_q && !refInvert_q &&
       !$past(refInvert_q) && $rose(referenceClock)) |=> refDivPulse;
  endproperty
  a_ref_div_one: assert property (p_ref_div_one)
    else $error("Reference divider with count zero did not divide by one.");

  // With the prescaler in force, an edge on the first half never advances the count.
  property p_ref_prescale;
    @(posedge clk) disable iff (rst)
      (u_ref_div.preEn_q && u_ref_div.inEdge && !u_ref_div.half_q) |-> !u_ref_div.countEdge;
  endproperty
  a_ref_prescale: assert property (p_ref_prescale)
    else $error("Reference prescaler let the first edge of a pair through.");

  // Feedback count of zero without prescaler also divides by one.
  property p_fb_div_one;
    @(posedge clk) disable iff (rst)
      (u_fb_div.limit_q == '0 && !u_fb_div.preEn_q && !fbInvert_q &&
       !$past(fbInvert_q) && $rose(feedbackClockInput)) |=> fbDivPulse;
  endproperty
  a_fb_div_one: assert property (p_fb_div_one)
    else $error("Feedback divider with count zero did not divide by one.");

  // Feedback output is a pulse as well: never high on two cycles in a row.
  property p_fb_pulse_single;
    @(posedge clk) disable iff (rst) fbDivPulse |=> !fbDivPulse;
  endproperty
  a_fb_pulse_single: assert property (p_fb_pulse_single)
    else $error("Feedback divider pulse lasted more than one cycle.");

  // With the feedback prescaler in force, the first edge of a pair is swallowed.
  property p_fb_prescale;
    @(posedge clk) disable iff (rst)
      (u_fb_div.preEn_q && u_fb_div.inEdge && !u_fb_div.half_q) |-> !u_fb_div.countEdge;
  endproperty
  a_fb_prescale: assert property (p_fb_prescale)
    else $error("Feedback prescaler let the first edge of a pair through.");

  // With invert set, a falling reference edge is the one that counts.
  property p_ref_invert_edge;
    @(posedge clk) disable iff (rst)
      (refInvert_q && $past(refInvert_q) && $fell(referenceClock)) |-> u_ref_div.inEdge;
  endproperty
  a_ref_invert_edge: assert property (p_ref_invert_edge)
    else $error("Inverted reference clock did not count on the falling edge.");

endmodule

// File: clock_source_model.sv
// Behavioural source for one divider input clock, standing in for a reference or feedback clock.
// Assumes clk is the block clock; the output changes just after a rising edge of clk.
`timescale 1ns/1ps
module clock_source_model
(
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [3:0] halfCycles,
  output logic            clockOut
);
  logic [3:0] phaseCnt_q;  // Cycles spent in the current half period.

  initial
  begin
    clockOut   = 1'b0;
    phaseCnt_q = 4'h0;
  end

  // The line stands still low while stopped, so no stray edge is offered between runs.
  always @(posedge clk)
  begin
    if (!run)
    begin
      clockOut   <= 1'b0;
      phaseCnt_q <= 4'h0;
    end
    else if (phaseCnt_q + 4'h1 >= halfCycles)
    begin
      clockOut   <= ~clockOut;
      phaseCnt_q <= 4'h0;
    end
    else
    begin
      phaseCnt_q <= phaseCnt_q + 4'h1;
    end
  end
endmodule

// File: dpll_ref_feedback_dividers_tb.sv
// Self-checking bench for the reference and feedback dividers and their register file.
// Assumes the package and the design files are compiled first; one 200 MHz clock only.
`timescale 1ns/1ps
module div_period_monitor
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic line,
  input  wire logic invert,
  input  wire logic pulse,
  output int        periodEdges,
  output int        pulses,
  output logic      phaseOk
);
  logic p1, p2, p3;  // Past samples of the line as the divider should see it.
  logic cur;         // Current sample after the expected inversion.
  int   edges;       // Active edges since the last output pulse.

  assign cur = line ^ invert;

  // Active edges are counted between pulses; the pulse must trail an active edge closely.
  always @(posedge clk)
  begin
    if (rst)
    begin
      {p1, p2, p3} <= 3'b000;
      edges        <= 0;
      pulses       <= 0;
      periodEdges  <= 0;
      phaseOk      <= 1'b0;
    end
    else
    begin
      {p1, p2, p3} <= {cur, p1, p2};
      if (pulse === 1'b1)
      begin
        pulses      <= pulses + 1;
        periodEdges <= edges;
        phaseOk     <= (p1 & ~p2) | (p2 & ~p3);
        edges       <= int'(cur & ~p1);
      end
      else
      begin
        edges <= edges + int'(cur & ~p1);
      end
    end
  end
endmodule

module dpll_ref_feedback_dividers_tb;
  import dpll_div_pkg::*;
  logic clk, rst, wbCyc, wbStb, wbWe, ack, outRef, outFb;
  logic [ADDR_W-1:0] wbAdr;
  logic [3:0] wbSel;
  logic [DAT_W-1:0] wbDat, rdDat;
  logic [31:0] seed;                // Random state, fixed start for repeatable runs.
  logic [15:0] cN[2];               // Count per channel: 0 reference, 1 feedback.
  logic cPre[2], cInv[2], cRun[2], src[2], pls[2];
  logic [3:0] cHalf[2];
  int periodE[2], pulseCnt[2], num_errors, checks;
  logic phOk[2];

  dpll_ref_feedback_dividers dut (.clk(clk), .rst(rst), .cyc_i(wbCyc), .stb_i(wbStb),
    .we_i(wbWe), .adr_i(wbAdr), .sel_i(wbSel), .dat_i(wbDat), .dat_o(rdDat), .ack_o(ack),
    .referenceClock(src[0]), .feedbackClockInput(src[1]), .refDivPulse(outRef),
    .fbDivPulse(outFb));
  assign pls[0] = outRef;
  assign pls[1] = outFb;

  // One source and one monitor for each divider.
  for (genvar g = 0; g < 2; g++)
  begin : gen_ch
    clock_source_model src_i (.clk(clk), .run(cRun[g]), .halfCycles(cHalf[g]),
      .clockOut(src[g]));
    div_period_monitor mon_i (.clk(clk), .rst(rst), .line(src[g]), .invert(cInv[g]),
      .pulse(pls[g]), .periodEdges(periodE[g]), .pulses(pulseCnt[g]), .phaseOk(phOk[g]));
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Active edges per output pulse: stored count plus one, doubled by the prescaler.
  function automatic int expEdges(input logic [15:0] n, input logic pre);
    return (int'(n) + 1) * (pre ? 2 : 1);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Classic cycle: hold the request until ack is sampled, then idle for one cycle.
  task automatic wbCycle(input logic [IDX_W-1:0] idx, input logic we, input logic [7:0] wd,
                         input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    {wbCyc, wbStb, wbWe, wbSel} <= {2'b11, we, sel};
    wbAdr <= {idx, 2'b00};
    wbDat <= {24'h00_0000, wd};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      check("bus answer", 32'h0000_0000, 32'h0000_0001);
    rd = rdDat;
    {wbCyc, wbStb} <= 2'b00;
    @(posedge clk);
  endtask

  task automatic waitPulses(input int ch, input int cnt);
    int base, n;
    base = pulseCnt[ch];
    n = 0;
    while (pulseCnt[ch] < base + cnt && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000)
      check("pulse arrival", 32'h0000_0000, 32'h0000_0001);
  endtask

  // Programs one channel; reserved control bits get random values that must do nothing.
  task automatic setup(input int ch);
    logic [31:0] rd;
    logic [IDX_W-1:0] b;
    b = ch ? IDX_FB_LOW : IDX_REF_LOW;
    seed = nextRand(seed);
    wbCycle(b, 1'b1, cN[ch][7:0], 4'hf, rd);
    wbCycle(b + 10'h1, 1'b1, cN[ch][15:8], 4'hf, rd);
    wbCycle(b + 10'h2, 1'b1, {cInv[ch], seed[6:1], cPre[ch]}, 4'hf, rd);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] rd;
    logic [7:0] wd;
    logic [IDX_W-1:0] idx;
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDat} = '0;
    {cRun[0], cRun[1], cInv[0], cInv[1]} = 4'h0;
    cHalf[0] = 4'h3;
    cHalf[1] = 4'h3;
    seed = 32'h3297_c161;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, byte placement, lane 0 gating and reserved control bits.
    for (int k = 0; k < 6; k++)
    begin
      idx = IDX_REF_LOW + 10'(k);
      wbCycle(idx, 1'b0, 8'h00, 4'hf, rd);
      check("reset value", rd, 32'h0000_0000);
      seed = nextRand(seed);
      wd = seed[7:0];
      wbCycle(idx, 1'b1, wd, 4'hf, rd);
      wbCycle(idx, 1'b1, ~wd, 4'he, rd);
      wbCycle(idx, 1'b0, 8'h00, 4'hf, rd);
      check("readback", rd, {24'h00_0000, (k % 3 == 2) ? (wd & 8'h81) : wd});
    end
    wbCycle(10'h0ff, 1'b1, 8'hff, 4'hf, rd);
    wbCycle(10'h0ff, 1'b0, 8'h00, 4'hf, rd);
    check("unmapped read", rd, 32'h0000_0000);
    // Ratio, prescaler and edge sense on both channels; first rounds are corner values.
    for (int k = 0; k < 6; k++)
    begin
      {cRun[0], cRun[1]} <= 2'b00;
      repeat (8) @(posedge clk);
      for (int ch = 0; ch < 2; ch++)
      begin
        seed = nextRand(seed);
        cN[ch] = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0100 : 16'(seed[9:8] % 3);
        cHalf[ch] = 4'h3 + 4'(seed[5:4] % 3);
        {cInv[ch], cPre[ch]} = seed[1:0];
        if (cHalf[ch] == 4'h3)
          cPre[ch] = 1'b1;
        setup(ch);
      end
      {cRun[0], cRun[1]} <= 2'b11;
      for (int ch = 0; ch < 2; ch++)
      begin
        waitPulses(ch, 3);
        check("period", 32'(periodE[ch]), 32'(expEdges(cN[ch], cPre[ch])));
        check("edge", 32'(phOk[ch]), 32'h0000_0001);
      end
    end
    // A count written mid-period only applies from the next terminal count.
    cRun[0] <= 1'b0;
    repeat (8) @(posedge clk);
    {cN[0], cInv[0], cPre[0], cHalf[0]} = {16'h0002, 2'b00, 4'h3};
    setup(0);
    cRun[0] <= 1'b1;
    waitPulses(0, 3);
    wbCycle(IDX_REF_LOW, 1'b1, 8'h05, 4'hf, rd);
    waitPulses(0, 1);
    check("old period", 32'(periodE[0]), 32'h0000_0003);
    waitPulses(0, 1);
    check("new period", 32'(periodE[0]), 32'h0000_0006);
    {cRun[0], cRun[1]} <= 2'b00;
    repeat (10) @(posedge clk);
    wbCycle(IDX_STATUS, 1'b0, 8'h00, 4'hf, rd);
    check("status", rd, {30'h0, 1'(pulseCnt[1]), 1'(pulseCnt[0])});
    print_verdict();
  end
endmodule
